// *** logic/lsbf_pkg.sv ***
// constants and types for the scan-limit and feature-control block
`default_nettype none
package lsbf_pkg;
  // register addresses as seen by the serial interface decoder
  localparam logic [7:0] ADDR_SCAN   = 8'h0b;
  localparam logic [7:0] ADDR_FEAT   = 8'h0e;
  // reset values
  localparam logic [7:0] SCAN_RST    = 8'h00;
  localparam logic [7:0] FEAT_RST    = 8'h00;
  // scan-limit field in bits 2:0
  localparam int         SCAN_LIM_LSB = 0;
  localparam int         DIG_W        = 3;
  localparam int         NUM_DIG      = 8;
  localparam int         IDX_W        = 4;
  // two blank slots per frame give the n+2 term of the refresh law
  localparam logic [3:0] GAP_SLOTS    = 4'h2;
  // timing
  localparam int SYS_CLK_HZ      = 250_000_000;
  localparam int REFRESH_FULL_HZ = 700;
  localparam int FULL_FRAME_SLOTS = 10;
  localparam int SLOT_CYC_DFLT   =
    SYS_CLK_HZ / (REFRESH_FULL_HZ * FULL_FRAME_SLOTS);
  localparam int BLINK_SHORT_MS  = 500;
  localparam int BLINK_LONG_MS   = 1000;
  localparam int BLINK_SHORT_CYC = (SYS_CLK_HZ / 1000) * BLINK_SHORT_MS;
  localparam int BLINK_LONG_CYC  = (SYS_CLK_HZ / 1000) * BLINK_LONG_MS;
  localparam int SLOT_W          = 16;
  localparam int BLINK_W         = 28;
  // feature register, bit 7 first
  typedef struct packed {
    logic blink_start;
    logic sync;
    logic blink_freq_sel;
    logic blink_en;
    logic not_used;
    logic decode_sel;
    logic reg_res;
    logic clk_en;
  } lsbf_feat_t;
  // what the current multiplex slot drives
  typedef enum logic {SLOT_DIGIT, SLOT_GAP} lsbf_slot_t;
endpackage
`default_nettype wire

// *** logic/lsbf_ctrl.sv ***
// scan-limit multiplexer and feature-control logic of the display driver
//
// Overview of operation
// - scan digits 0 to limit field only
// - refresh equals ten fosc over digits plus two
// - feature register clears to zero at reset
// - bit 0 selects external clock pin
// - bit 1 resets control registers, not feature
// - soft reset keeps digit data intact
// - bit 2 selects code-b or hex decoding
// - bit 4 enables periodic blinking
// - bit 5 selects one or two second period
// - sync bit clears timing on pin rise
// - bit 7 sets starting blink phase
// - key result invalid while blinking
`timescale 1ns/1ps
`default_nettype none
module lsbf_ctrl #(
  parameter int SLOT_CYC        = lsbf_pkg::SLOT_CYC_DFLT,
  parameter int BLINK_SHORT_CYC = lsbf_pkg::BLINK_SHORT_CYC,
  parameter int BLINK_LONG_CYC  = lsbf_pkg::BLINK_LONG_CYC
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RESETN,
  input  wire logic       WR_EN,
  input  wire logic [7:0] WR_ADDR,
  input  wire logic [7:0] WR_DATA,
  input  wire logic [7:0] RD_ADDR,
  output var  logic [7:0] RD_DATA,
  input  wire logic       EXT_CLK_PIN,
  input  wire logic       LOAD_CHIP_SELECT_PIN,
  input  wire logic [7:0] SEG_IN,
  output var  logic [7:0] SEG_OUT,
  output var  logic [7:0] DIGIT_OUT,
  output var  logic [2:0] DIGIT_IDX,
  output var  logic       CLK_SEL_EXT,
  output var  logic       DECODE_HEX,
  output var  logic       CTRL_RST,
  output var  logic       KEY_VALID
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (SLOT_CYC < 1 || SLOT_CYC >= (1 << lsbf_pkg::SLOT_W))
    $error("slot count out of range");
  if (BLINK_SHORT_CYC < 1 || BLINK_LONG_CYC >= (1 << lsbf_pkg::BLINK_W))
    $error("blink count out of range");

  localparam logic [lsbf_pkg::SLOT_W-1:0]  SLOT_LAST =
    lsbf_pkg::SLOT_W'(SLOT_CYC - 1);
  localparam logic [lsbf_pkg::BLINK_W-1:0] HALF_SHORT =
    lsbf_pkg::BLINK_W'(BLINK_SHORT_CYC - 1);
  localparam logic [lsbf_pkg::BLINK_W-1:0] HALF_LONG =
    lsbf_pkg::BLINK_W'(BLINK_LONG_CYC - 1);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  lsbf_pkg::lsbf_feat_t            feat_reg;
  logic [7:0]                      scan_reg;
  logic                            ext_prev_reg;
  logic                            lcs_prev_reg;
  logic [lsbf_pkg::SLOT_W-1:0]     slot_cnt_reg;
  logic [lsbf_pkg::IDX_W-1:0]      slot_idx_reg;
  logic [lsbf_pkg::BLINK_W-1:0]    blink_cnt_reg;
  logic                            blink_on_reg;
  logic                            blink_en_prev_reg;
  logic [lsbf_pkg::DIG_W-1:0]      scan_lim;
  logic [lsbf_pkg::IDX_W-1:0]      slot_top;
  logic [lsbf_pkg::BLINK_W-1:0]    half_last;
  logic                            tick;
  logic                            sync_clr;
  logic                            slot_end;
  logic                            blink_restart;
  lsbf_pkg::lsbf_slot_t            slot_kind;

  assign scan_lim = scan_reg[lsbf_pkg::SCAN_LIM_LSB +: lsbf_pkg::DIG_W];
  // digit slots plus two blank slots per frame
  assign slot_top = lsbf_pkg::IDX_W'(scan_lim) + lsbf_pkg::GAP_SLOTS;

  // feature register, never touched by its own soft reset
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      feat_reg <= lsbf_pkg::FEAT_RST;
    else if (WR_EN && WR_ADDR == lsbf_pkg::ADDR_FEAT)
      feat_reg <= WR_DATA;
  end

  // scan-limit register
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      scan_reg <= lsbf_pkg::SCAN_RST;
    // held at default while soft reset bit is set
    else if (feat_reg.reg_res)
      scan_reg <= lsbf_pkg::SCAN_RST;
    else if (WR_EN && WR_ADDR == lsbf_pkg::ADDR_SCAN)
      scan_reg <= WR_DATA;
  end

  // read-back, one cycle latency, unmapped reads zero
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      RD_DATA <= 8'h00;
    else if (RD_ADDR == lsbf_pkg::ADDR_FEAT)
      RD_DATA <= feat_reg;
    else if (RD_ADDR == lsbf_pkg::ADDR_SCAN)
      RD_DATA <= scan_reg;
    else
      RD_DATA <= 8'h00;
  end

  // ----------------------------------------------------------------
  // timebase and pin edges
  // ----------------------------------------------------------------
  // pin edges; both pins are already synchronous
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      ext_prev_reg <= 1'b0;
      lcs_prev_reg <= 1'b0;
    end
    else
    begin
      ext_prev_reg <= EXT_CLK_PIN;
      lcs_prev_reg <= LOAD_CHIP_SELECT_PIN;
    end
  end

  // external mode counts pin rising edges instead of cycles
  assign tick = feat_reg.clk_en ? (EXT_CLK_PIN & ~ext_prev_reg) : 1'b1;
  // pin rise clears timing when sync is set
  assign sync_clr = feat_reg.sync & LOAD_CHIP_SELECT_PIN & ~lcs_prev_reg;
  assign slot_end = tick && slot_cnt_reg == SLOT_LAST;

  // ----------------------------------------------------------------
  // multiplexer
  // ----------------------------------------------------------------
  // slot index walks 0..limit+2 and wraps
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN || sync_clr)
    begin
      slot_cnt_reg <= '0;
      slot_idx_reg <= '0;
    end
    else if (slot_end)
    begin
      slot_cnt_reg <= '0;
      // >= guards a limit shrunk below the current slot
      slot_idx_reg <= (slot_idx_reg >= slot_top) ? '0 : slot_idx_reg + 4'h1;
    end
    else if (tick)
      slot_cnt_reg <= slot_cnt_reg + 1'b1;
  end

  // slot kind from index and limit
  always_comb
  begin
    case (slot_idx_reg <= lsbf_pkg::IDX_W'(scan_lim))
      1'b1:    slot_kind = lsbf_pkg::SLOT_DIGIT;
      1'b0:    slot_kind = lsbf_pkg::SLOT_GAP;
      default: slot_kind = lsbf_pkg::SLOT_GAP;
    endcase
  end

  // ----------------------------------------------------------------
  // blink timing
  // ----------------------------------------------------------------
  // half period by freq select
  assign half_last = feat_reg.blink_freq_sel ? HALF_LONG : HALF_SHORT;
  assign blink_restart = sync_clr | (feat_reg.blink_en & ~blink_en_prev_reg);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      blink_en_prev_reg <= 1'b0;
    else
      blink_en_prev_reg <= feat_reg.blink_en;
  end

  // blinking only while enabled; otherwise display stays on
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN || !feat_reg.blink_en)
    begin
      blink_cnt_reg <= '0;
      blink_on_reg  <= 1'b1;
    end
    else if (blink_restart)
    begin
      blink_cnt_reg <= '0;
      blink_on_reg  <= feat_reg.blink_start;
    end
    else if (tick && blink_cnt_reg >= half_last)
    begin
      blink_cnt_reg <= '0;
      blink_on_reg  <= ~blink_on_reg;
    end
    else if (tick)
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // digit index, digit lines and segments all registered together, one cycle after the slot index
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      DIGIT_OUT <= 8'h00;
      DIGIT_IDX <= 3'h0;
      SEG_OUT   <= 8'h00;
    end
    else
    begin
      DIGIT_IDX <= slot_idx_reg[lsbf_pkg::DIG_W-1:0];
      // one digit line at a time
      DIGIT_OUT <= (slot_kind == lsbf_pkg::SLOT_DIGIT) ?
                   8'h01 << slot_idx_reg[lsbf_pkg::DIG_W-1:0] : 8'h00;
      // blank in off phase, stored data untouched
      SEG_OUT   <= (slot_kind == lsbf_pkg::SLOT_DIGIT && blink_on_reg) ?
                   SEG_IN : 8'h00;
    end
  end

  // mode outputs toward clock mux, decoder and keyscan
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      CLK_SEL_EXT <= 1'b0;
      DECODE_HEX  <= 1'b0;
      CTRL_RST    <= 1'b0;
      KEY_VALID   <= 1'b1;
    end
    else
    begin
      CLK_SEL_EXT <= feat_reg.clk_en;
      DECODE_HEX  <= feat_reg.decode_sel;
      // control reset only; digit data registers not wired to it
      CTRL_RST    <= feat_reg.reg_res;
      // key result flagged invalid while blinking
      KEY_VALID   <= ~feat_reg.blink_en;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  feat_write_a: assert property (
    WR_EN && WR_ADDR == lsbf_pkg::ADDR_FEAT |=> feat_reg == $past(WR_DATA))
    else $error("feature write lost");
  digit_limit_a: assert property (
    DIGIT_OUT != 8'h00 |-> DIGIT_IDX <= $past(scan_lim))
    else $error("digit beyond limit");
  one_hot_a: assert property ($onehot0(DIGIT_OUT))
    else $error("more than one digit driven");
  soft_rst_a: assert property (
    feat_reg.reg_res |=> scan_reg == lsbf_pkg::SCAN_RST &&
    ($stable(feat_reg) || $past(WR_EN)))
    else $error("soft reset failed");
  slot_wrap_a: assert property (slot_end && slot_idx_reg >= slot_top
    && !sync_clr |=> slot_idx_reg == 4'h0) else $error("slot did not wrap");
  sync_clear_a: assert property (sync_clr |=> slot_cnt_reg == '0
    && slot_idx_reg == '0 && blink_cnt_reg == '0)
    else $error("sync did not clear");
  blink_start_a: assert property (feat_reg.blink_en
    && !blink_en_prev_reg |=> blink_on_reg == $past(feat_reg.blink_start))
    else $error("wrong start phase");
  blank_off_a: assert property (!blink_on_reg |=> SEG_OUT == 8'h00)
    else $error("segments lit in off phase");
  key_valid_a: assert property (feat_reg.blink_en |=> !KEY_VALID)
    else $error("key flagged valid while blinking");
  decode_sel_a: assert property (
    ##1 DECODE_HEX == $past(feat_reg.decode_sel)
    && CLK_SEL_EXT == $past(feat_reg.clk_en))
    else $error("mode output mismatch");

  wrap_c: cover property (slot_end && slot_idx_reg == slot_top);
  blink_toggle_c: cover property (feat_reg.blink_en && $changed(blink_on_reg));
  sync_c: cover property (sync_clr);
endmodule
`default_nettype wire

// *** tb/lsbf_host_model.sv ***
// host-side model that writes and reads the control registers
`timescale 1ns/1ps
`default_nettype none
module lsbf_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output var  logic       wr_en,
  output var  logic [7:0] wr_addr,
  output var  logic [7:0] wr_data,
  output var  logic [7:0] rd_addr,
  output var  logic       load_pin
);
  // idle bus at time zero
  initial
  begin
    wr_en    = 1'b0;
    wr_addr  = 8'h00;
    wr_data  = 8'h00;
    rd_addr  = 8'h00;
    load_pin = 1'b0;
  end
  // one-cycle write strobe; the model writes both the scan-limit and feature registers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en   = 1'b0;
    wr_data = ~d;  // stale data must not look valid
  endtask
  // read data is registered, so sample one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    d = rd_data;
  endtask
  // low then high so a rising edge is seen
  task automatic load_rise();
    @(negedge clk);
    load_pin = 1'b0;
    @(negedge clk);
    load_pin = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** tb/test_led_scan_blink_feature_ctrl.sv ***
// self-checking bench for the scan-limit and feature-control block
`timescale 1ns/1ps
`default_nettype none
module test_led_scan_blink_feature_ctrl;
  localparam int SLOT = 4;
  localparam int HS   = 20;
  localparam int HL   = 40;
  logic       clk_sys = 1'b0;
  logic       resetn;
  logic       wr_en, ld, ext_clk;
  logic [7:0] wa, wd, ra, rdat, seg_in, seg, dig, d;
  logic [2:0] idx;
  logic       cse, dhex, crst, kv;
  int         miscompares = 0;
  int         comparisons = 0;
  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  always #2 clk_sys = ~clk_sys;
  lsbf_ctrl #(.SLOT_CYC(SLOT), .BLINK_SHORT_CYC(HS), .BLINK_LONG_CYC(HL))
  i_lsbf_ctrl (.CLK_SYS(clk_sys), .RESETN(resetn), .WR_EN(wr_en),
    .WR_ADDR(wa), .WR_DATA(wd), .RD_ADDR(ra), .RD_DATA(rdat),
    .EXT_CLK_PIN(ext_clk), .LOAD_CHIP_SELECT_PIN(ld), .SEG_IN(seg_in),
    .SEG_OUT(seg), .DIGIT_OUT(dig), .DIGIT_IDX(idx), .CLK_SEL_EXT(cse),
    .DECODE_HEX(dhex), .CTRL_RST(crst), .KEY_VALID(kv));
  lsbf_host_model i_lsbf_host_model (.clk(clk_sys), .rd_data(rdat),
    .wr_en(wr_en), .wr_addr(wa), .wr_data(wd), .rd_addr(ra), .load_pin(ld));
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one full frame: each scanned digit lit SLOT cycles, two blank slots
  task automatic scan_frame(input int n);
    int cnt[8];
    int z, lit, bad;
    cnt = '{default: 0};
    z = 0;
    lit = 0;
    bad = 0;
    repeat (44) @(negedge clk_sys);
    repeat ((n + 3) * SLOT)
    begin
      @(negedge clk_sys);
      if (dig == 8'h00) z++;
      if (!$onehot0(dig)) bad++;
      for (int k = 0; k < 8; k++) if (dig[k]) cnt[k]++;
      if (seg != 8'h00) lit++;
    end
    for (int k = 0; k < 8; k++)
      chk("digit time", 8'((k <= n) ? SLOT : 0), 8'(cnt[k]));
    chk("gap time", 8'(2 * SLOT), 8'(z));
    chk("one hot", 8'h00, 8'(bad));
    chk("lit time", 8'((n + 1) * SLOT), 8'(lit));
  endtask
  // blink phases after a synchronising pin edge
  task automatic blink_case(input logic fs, input logic st);
    int h, on1, on2;
    h = fs ? HL : HS;
    on1 = 0;
    on2 = 0;
    i_lsbf_host_model.wr(lsbf_pkg::ADDR_FEAT, {st, 2'b11 & {1'b1, fs}, 5'h10});
    i_lsbf_host_model.load_rise();
    for (int i = 0; i < 2 * h; i++)
    begin
      @(negedge clk_sys);
      if (i >= 3 && i <= h - 3 && seg != 8'h00) on1++;
      if (i >= h + 3 && i <= 2 * h - 3 && seg != 8'h00) on2++;
    end
    chk("first phase", {7'h0, st}, {7'h0, on1 != 0});
    chk("second phase", {7'h0, !st}, {7'h0, on2 != 0});
    chk("key valid", 8'h00, {7'h0, kv});
  endtask
  // ----------------------------------------
  // stimulus and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end
  initial
  begin
    resetn = 1'b0;
    ext_clk = 1'b0;
    seg_in = 8'hff;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    i_lsbf_host_model.rd(lsbf_pkg::ADDR_FEAT, d);
    chk("feature reset", 8'h00, d);
    chk("key valid", 8'h01, {7'h0, kv});
    i_lsbf_host_model.wr(lsbf_pkg::ADDR_FEAT, 8'h04);
    repeat (2) @(negedge clk_sys);
    chk("decode hex", 8'h01, {7'h0, dhex});
    i_lsbf_host_model.wr(lsbf_pkg::ADDR_FEAT, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk("clock select", 8'h03, {6'h0, cse, !dhex});
    d = {5'h0, idx};
    repeat (20) @(negedge clk_sys);
    chk("idle pin frozen", d, {5'h0, idx});
    i_lsbf_host_model.wr(lsbf_pkg::ADDR_SCAN, 8'h03);
    i_lsbf_host_model.wr(lsbf_pkg::ADDR_FEAT, 8'h02);
    i_lsbf_host_model.wr(lsbf_pkg::ADDR_SCAN, 8'h05);
    i_lsbf_host_model.rd(lsbf_pkg::ADDR_SCAN, d);
    chk("scan soft reset", 8'h00, d);
    chk("ctrl reset out", 8'h01, {7'h0, crst});
    i_lsbf_host_model.rd(lsbf_pkg::ADDR_FEAT, d);
    chk("feature kept", 8'h02, d);
    // unmapped read right after a nonzero one, so stale data shows
    i_lsbf_host_model.rd(8'h55, d);
    chk("unmapped", 8'h00, d);
    i_lsbf_host_model.wr(lsbf_pkg::ADDR_FEAT, 8'h00);
    for (int n = 0; n < 8; n++)
    begin
      i_lsbf_host_model.wr(lsbf_pkg::ADDR_SCAN, 8'hf8 | 8'(n));
      scan_frame(n);
    end
    for (int c = 0; c < 4; c++)
      blink_case(c[1], c[0]);
    i_lsbf_host_model.wr(lsbf_pkg::ADDR_FEAT, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk("key valid", 8'h01, {7'h0, kv});
    // pin clocking: three slots worth of pin edges after a sync
    i_lsbf_host_model.wr(lsbf_pkg::ADDR_FEAT, 8'h41);
    i_lsbf_host_model.load_rise();
    repeat (3 * SLOT)
    begin
      @(negedge clk_sys);
      ext_clk = 1'b1;
      @(negedge clk_sys);
      ext_clk = 1'b0;
    end
    repeat (2) @(negedge clk_sys);
    chk("pin clocked index", 8'h03, {5'h0, idx});
    // mid-run reset must clear a nonzero feature register again
    @(negedge clk_sys);
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    i_lsbf_host_model.rd(lsbf_pkg::ADDR_FEAT, d);
    chk("feature mid reset", 8'h00, d);
    chk("clock select reset", 8'h00, {7'h0, cse});
    close_out();
  end
endmodule
`default_nettype wire
